// ===== core/isb_pkg.sv
// package of constants and carrier types for the isolated spi bridge port control
package isb_pkg;
  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned IDLE_TIME_US    = 5700;
  localparam int unsigned IDLE_CYCLES     = IDLE_TIME_US * CLK_MHZ;
  localparam int unsigned WAKE_TIME_NS    = 8000;
  localparam int unsigned WAKE_CYCLES     = WAKE_TIME_NS * CLK_MHZ / 1000;
  localparam int unsigned LONG_HALF_NS    = 150;
  localparam int unsigned SHORT_HALF_NS   = 50;
  localparam int unsigned LONG_HALF_CYC   = (LONG_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHORT_HALF_CYC  = (SHORT_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCK_HALF_FAST_NS = 120;
  localparam int unsigned SCK_HALF_SLOW_NS = 1100;
  localparam int unsigned SCK_FAST_CYC    = (SCK_HALF_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCK_SLOW_CYC    = (SCK_HALF_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LONG_MIN_CYC    = 5;
  localparam int unsigned CNT_W           = 19;

  typedef enum logic [1:0] {
    isb_p_long_pos,
    isb_p_long_neg,
    isb_p_short_pos,
    isb_p_short_neg
  } isb_pulse_e;

  typedef struct packed {
    logic       valid;
    isb_pulse_e kind;
  } isb_pulse_s;

  // pin carrier for open-drain and push-pull spi pins
  typedef struct packed {
    logic o;
    logic oe;
  } isb_pin_s;
endpackage : isb_pkg

// ===== core/isb_pulse_tx.sv
// symmetric pulse pair transmitter onto the plus/minus link pins
`timescale 1ns/100ps
`default_nettype none
module isb_pulse_tx (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // request
  input  wire isb_pkg::isb_pulse_s req,
  output logic             busy,
  // link drive
  output logic             drv_plus,
  output logic             drv_minus
);
  typedef struct packed {
    logic       act;
    logic       second;
    logic       neg_first;
    logic [3:0] cnt;
    logic [3:0] half;
    logic       p;
    logic       m;
  } isb_tx_s;

  isb_tx_s st;
  isb_tx_s next_st;

  always_comb begin
    next_st = st;
    if (!st.act) begin
      if (req.valid) begin
        next_st.act       = 1'b1;
        next_st.second    = 1'b0;
        next_st.neg_first = (req.kind == isb_pkg::isb_p_long_neg) ||
                            (req.kind == isb_pkg::isb_p_short_neg);
        next_st.half      = (req.kind == isb_pkg::isb_p_long_pos ||
                             req.kind == isb_pkg::isb_p_long_neg) ?
                            4'(isb_pkg::LONG_HALF_CYC) : 4'(isb_pkg::SHORT_HALF_CYC);
        next_st.cnt       = 4'h1;
        next_st.p         = !next_st.neg_first;
        next_st.m         = next_st.neg_first;
      end
    end else if (st.cnt == st.half) begin
      next_st.cnt = 4'h1;
      if (st.second) begin
        next_st.act = 1'b0;
        next_st.p   = 1'b0;
        next_st.m   = 1'b0;
      end else begin
        // second half inverts so the pair carries no dc
        next_st.second = 1'b1;
        next_st.p      = st.neg_first;
        next_st.m      = !st.neg_first;
      end
    end else begin
      next_st.cnt = st.cnt + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign busy      = st.act;
  assign drv_plus  = st.p;
  assign drv_minus = st.m;
endmodule : isb_pulse_tx
`default_nettype wire

// ===== core/isb_port_ctrl.sv
// role, spi pin direction and idle/wake control of the isolated spi bridge
// Summary of operation
// - master role: mosi is input; slave role: mosi driven toward slave
// - master role: miso driven toward master; slave role: miso sampled input
// - mosi and miso drive only low or release; pull-up gives high
// - sck input in master role, push-pull output in slave role
// - cs input in master role, push-pull output in slave role
// - role strap high selects master, low selects slave
// - enable high keeps device active, never idle
// - enable low: idle after 5.7ms cs high or link silence
// - from idle, fully active within 8us of cs fall or link signal
// - polarity and phase straps are static configuration
// - master in run state sends long pulses for cs edges, short for latching edges; the cs fall that wakes it from idle sends none
// - slave acts on pulses, returns short -1 on cs fall or miso zero
// - polarity sets idle clock level, phase picks latching edge
`timescale 1ns/100ps
`default_nettype none
module isb_port_ctrl (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // straps and enable
  input  wire logic             role_select,
  input  wire logic             slow_timing_select,
  input  wire logic             clock_polarity_strap,
  input  wire logic             clock_phase_strap,
  input  wire logic             enable,
  // spi pins
  input  wire logic             mosi_in,
  output isb_pkg::isb_pin_s     mosi_out,
  input  wire logic             miso_in,
  output isb_pkg::isb_pin_s     miso_out,
  input  wire logic             sck_in,
  output isb_pkg::isb_pin_s     sck_out,
  input  wire logic             cs_in,
  output isb_pkg::isb_pin_s     cs_out,
  // link comparator inputs and drive
  input  wire logic             link_plus_in,
  input  wire logic             link_minus_in,
  output logic                  link_plus,
  output logic                  link_minus,
  output logic                  link_oe,
  // status
  output logic                  awake
);
  typedef enum logic [2:0] {
    isb_s_idle, isb_s_wake, isb_s_run, isb_s_sck1, isb_s_sck2, isb_s_ret
  } isb_state_e;

  typedef struct packed {
    logic [1:0]                    s_mosi, s_miso, s_sck, s_cs, s_lp, s_lm;
    logic                          sck_d, cs_d;
    logic                          role, cpol, cpha, slow;
    isb_state_e                    fsm;
    logic [isb_pkg::CNT_W-1:0]     quiet;
    logic [8:0]                    wcnt;
    logic [5:0]                    tcnt;
    logic                          mosi_q, cs_q, miso_low, ret_pend;
    logic [3:0]                    plen;
    logic                          pneg, pval;
    isb_pkg::isb_pulse_s           txreq;
    logic                          started;
  } isb_st_s;

  isb_st_s st;
  isb_st_s next_st;
  logic    tx_busy;
  logic    drv_p;
  logic    drv_m;

  // which sck edge latches, for master edge detection
  function automatic logic is_latch_edge(input logic cpol, input logic cpha,
                                         input logic rising);
    is_latch_edge = rising ^ cpol ^ cpha;
  endfunction : is_latch_edge

  logic sck_rise;
  logic sck_fall;
  logic cs_rise;
  logic cs_fall;
  logic seen;
  logic [3:0] half_cyc;
  assign sck_rise = st.s_sck[1] && !st.sck_d;
  assign sck_fall = !st.s_sck[1] && st.sck_d;
  assign cs_rise  = st.s_cs[1] && !st.cs_d;
  assign cs_fall  = !st.s_cs[1] && st.cs_d;
  assign seen     = st.s_lp[1] ^ st.s_lm[1];
  assign half_cyc = 4'(isb_pkg::SHORT_HALF_CYC);

  always_comb begin
    next_st = st;
    next_st.txreq = '0;
    // pin inputs pass two flops before any logic reads them
    next_st.s_mosi = {st.s_mosi[0], mosi_in};
    next_st.s_miso = {st.s_miso[0], miso_in};
    next_st.s_sck  = {st.s_sck[0], sck_in};
    next_st.s_cs   = {st.s_cs[0], cs_in};
    next_st.s_lp   = {st.s_lp[0], link_plus_in};
    next_st.s_lm   = {st.s_lm[0], link_minus_in};
    next_st.sck_d  = st.s_sck[1];
    next_st.cs_d   = st.s_cs[1];
    // straps caught once after reset release; they are static
    if (!st.started) begin
      next_st.started = 1'b1;
      next_st.role    = role_select;
      next_st.cpol    = clock_polarity_strap;
      next_st.cpha    = clock_phase_strap;
      next_st.slow    = slow_timing_select;
      next_st.cs_q    = 1'b1;
      next_st.sck_d   = clock_polarity_strap;
    end
    // pulse classifier: measure first half width on the link
    if (seen) begin
      if (!st.pval) begin
        next_st.pval = 1'b1;
        next_st.pneg = st.s_lm[1];
        next_st.plen = 4'h1;
      end else if (st.s_lm[1] == st.pneg && st.plen != 4'hF) begin
        next_st.plen = st.plen + 4'h1;
      end
    end else begin
      next_st.pval = 1'b0;
    end
    // inactivity counter for idle entry
    if ((st.role && !st.s_cs[1]) || (!st.role && seen) || tx_busy) begin
      next_st.quiet = '0;
    end else if (st.quiet != isb_pkg::CNT_W'(isb_pkg::IDLE_CYCLES)) begin
      next_st.quiet = st.quiet + isb_pkg::CNT_W'(1);
    end
    case (st.fsm)
      isb_s_idle: begin
        if (enable || (st.role ? cs_fall : seen)) begin
          next_st.fsm  = isb_s_wake;
          next_st.wcnt = '0;
        end
      end
      isb_s_wake: begin
        // wake time is far below the 8us bound
        next_st.wcnt = st.wcnt + 9'h001;
        if (st.wcnt == 9'h004) begin
          next_st.fsm = isb_s_run;
          if (st.role && cs_fall) begin
            next_st.txreq = '{valid: 1'b1, kind: isb_pkg::isb_p_long_neg};
          end
        end
      end
      isb_s_run: begin
        if (!enable && st.quiet == isb_pkg::CNT_W'(isb_pkg::IDLE_CYCLES)) begin
          next_st.fsm = isb_s_idle;
        end else if (st.role) begin
          if (cs_rise) begin
            next_st.txreq    = '{valid: 1'b1, kind: isb_pkg::isb_p_long_pos};
            next_st.miso_low = 1'b0;
          end else if (cs_fall) begin
            next_st.txreq = '{valid: 1'b1, kind: isb_pkg::isb_p_long_neg};
          end else if ((sck_rise && is_latch_edge(st.cpol, st.cpha, 1'b1)) ||
                       (sck_fall && is_latch_edge(st.cpol, st.cpha, 1'b0))) begin
            next_st.txreq    = '{valid: 1'b1, kind: st.s_mosi[1] ?
                                  isb_pkg::isb_p_short_pos : isb_pkg::isb_p_short_neg};
            next_st.miso_low = 1'b0;
          end
          // short -1 return after our data pulse pulls miso low
          if (!seen && st.pval && st.pneg && st.plen <= half_cyc + 4'h1 && !tx_busy) begin
            next_st.miso_low = 1'b1;
          end
        end else if (!seen && st.pval && !tx_busy) begin
          if (st.plen >= 4'(isb_pkg::LONG_MIN_CYC)) begin
            next_st.cs_q = !st.pneg;
            if (st.pneg) begin
              next_st.ret_pend = 1'b1;
              next_st.fsm      = isb_s_ret;
            end
          end else begin
            next_st.mosi_q = !st.pneg;
            next_st.tcnt   = '0;
            next_st.fsm    = isb_s_sck1;
          end
        end
      end
      isb_s_sck1: begin
        next_st.tcnt = st.tcnt + 6'h01;
        if (st.tcnt == (st.slow ? 6'(isb_pkg::SCK_SLOW_CYC) : 6'(isb_pkg::SCK_FAST_CYC))) begin
          next_st.tcnt = '0;
          next_st.fsm  = isb_s_sck2;
        end
      end
      isb_s_sck2: begin
        next_st.tcnt = st.tcnt + 6'h01;
        if (st.tcnt == (st.slow ? 6'(isb_pkg::SCK_SLOW_CYC) : 6'(isb_pkg::SCK_FAST_CYC))) begin
          next_st.ret_pend = !st.s_miso[1];
          next_st.fsm      = isb_s_ret;
        end
      end
      isb_s_ret: begin
        // slave returns only short -1, so multiple slaves never collide
        if (st.ret_pend) begin
          next_st.txreq = '{valid: 1'b1, kind: isb_pkg::isb_p_short_neg};
        end
        next_st.ret_pend = 1'b0;
        next_st.fsm      = isb_s_run;
      end
      default: next_st.fsm = isb_s_idle;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  isb_pulse_tx u_tx (
    .mclk      (mclk),
    .srst      (srst),
    .req       (st.txreq),
    .busy      (tx_busy),
    .drv_plus  (drv_p),
    .drv_minus (drv_m)
  );

  // slave sck: idle level from polarity, two edges per data pulse
  logic sck_level;
  assign sck_level = (st.fsm == isb_s_sck1 && st.cpha) || (st.fsm == isb_s_sck2 && !st.cpha) ?
                     !st.cpol : st.cpol;

  always_comb begin
    mosi_out = '{o: 1'b0, oe: st.started && !st.role && !st.mosi_q};
    miso_out = '{o: 1'b0, oe: st.started && st.role && st.miso_low};
    sck_out  = '{o: sck_level, oe: st.started && !st.role};
    cs_out   = '{o: st.cs_q, oe: st.started && !st.role};
  end

  assign link_plus  = drv_p;
  assign link_minus = drv_m;
  assign link_oe    = tx_busy;
  assign awake      = st.fsm != isb_s_idle;
endmodule : isb_port_ctrl
`default_nettype wire

// ===== verif/isb_port_ctrl_props.sv
// assertion checker for the bridge port control
`timescale 1ns/100ps
`default_nettype none
module isb_port_ctrl_props (
  // clock and reset
  input wire logic              mclk,
  input wire logic              srst,
  // straps and pins
  input wire logic              role_select,
  input wire logic              clock_polarity_strap,
  input wire logic              enable,
  input wire logic              cs_in,
  input wire isb_pkg::isb_pin_s mosi_out,
  input wire isb_pkg::isb_pin_s miso_out,
  input wire isb_pkg::isb_pin_s sck_out,
  input wire isb_pkg::isb_pin_s cs_out,
  // link and status
  input wire logic              link_plus,
  input wire logic              link_minus,
  input wire logic              link_oe,
  input wire logic              awake
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_mosi_master_in: assert property (role_select |-> !mosi_out.oe)
    else $error("mosi driven in master role");
  a_miso_slave_in: assert property (!role_select |-> !miso_out.oe)
    else $error("miso driven in slave role");
  a_open_drain_low: assert property (!mosi_out.o && !miso_out.o)
    else $error("data line driven high");
  a_master_pins_in: assert property (role_select |-> !sck_out.oe && !cs_out.oe)
    else $error("clock or select driven in master role");
  a_slave_pins_out: assert property (!role_select && awake |-> sck_out.oe && cs_out.oe)
    else $error("clock or select not driven in slave role");
  a_enable_awake: assert property (enable [*8] |-> awake)
    else $error("asleep while enabled");
  a_cs_fall_pulse: assert property (role_select && $fell(cs_in) |->
    ##[2:6] (link_oe && link_minus && !link_plus) [*8]
    ##1 (link_oe && link_plus && !link_minus) [*8])
    else $error("bad long minus pulse");
  a_slave_return: assert property (!role_select && $rose(link_oe) |->
    (link_minus && !link_plus) [*3] ##1 (link_plus && !link_minus) [*3] ##1 !link_oe)
    else $error("bad slave return pulse");
  a_sck_idle_lvl: assert property (!role_select && awake && cs_out.o |->
    sck_out.o == clock_polarity_strap)
    else $error("clock idle level wrong");
  cover property (role_select && $fell(cs_in));
  cover property (!role_select && $rose(link_oe));
  cover property (role_select && $rose(miso_out.oe));
  cover property (!role_select && $rose(awake));
endmodule : isb_port_ctrl_props
bind isb_port_ctrl isb_port_ctrl_props isb_port_ctrl_props_i (.mclk, .srst, .role_select,
  .clock_polarity_strap, .enable, .cs_in, .mosi_out, .miso_out, .sck_out, .cs_out,
  .link_plus, .link_minus, .link_oe, .awake);
`default_nettype wire

// ===== verif/isb_spi_slave_model.sv
// spi slave model answering on the open-drain data-out line
`timescale 1ns/100ps
`default_nettype none
module isb_spi_slave_model (
  // clock
  input wire logic       mclk,
  // spi pins seen by the slave, mode and reply pattern
  input wire logic       cs_line,
  input wire logic       sck_line,
  input wire logic       cpol,
  input wire logic       cpha,
  input wire logic [1:0] pattern,
  // high pulls the data-out line low
  output logic           miso_pull
);
  logic       sck_q = 1'b0;
  logic [1:0] idx   = 2'h0;
  logic [1:0] bitn;
  // shift on the non-latching edge so data is steady at the latch
  always @(posedge mclk) begin
    sck_q <= sck_line;
    if (cs_line)
      idx <= 2'h0;
    else if (sck_q != sck_line && sck_line == (cpol ^ cpha))
      idx <= idx + 2'h1;
  end
  // phase high: the leading edge loads the first bit
  assign bitn      = idx - {1'b0, cpha};
  // released when deselected or out of bits, pull-up wins
  assign miso_pull = !cs_line && bitn < 2'h2 && !pattern[bitn[0]];
endmodule : isb_spi_slave_model
`default_nettype wire

// ===== verif/tb_top.sv
// testbench for the bridge port control
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk = 1'b0, srst = 1'b1, role = 1'b1, cpol = 1'b0;
  logic cpha = 1'b0, slow = 1'b0, en = 1'b1;
  logic m_cs = 1'b1, m_sck = 1'b0, m_mosi = 1'b0, lp_in = 1'b0, lm_in = 1'b0;
  isb_pkg::isb_pin_s mosi_out, miso_out, sck_out, cs_out;
  logic link_plus, link_minus, link_oe, awake, miso_pull, neg;
  logic mosi_line, miso_line, sck_line, cs_line;
  logic [31:0] h1, h2;
  int   err_total = 0;
  int   comparisons = 0;
  always #10 mclk = ~mclk;
  // open-drain data lines resolve against pull-ups
  assign mosi_line = role ? m_mosi : !mosi_out.oe;
  assign miso_line = !(miso_out.oe || (!role && miso_pull));
  assign sck_line  = sck_out.oe ? sck_out.o : m_sck;
  assign cs_line   = cs_out.oe ? cs_out.o : m_cs;
  isb_port_ctrl isb_port_ctrl_i (.mclk, .srst, .role_select(role),
    .slow_timing_select(slow), .clock_polarity_strap(cpol), .clock_phase_strap(cpha),
    .enable(en), .mosi_in(mosi_line), .mosi_out, .miso_in(miso_line), .miso_out,
    .sck_in(sck_line), .sck_out, .cs_in(cs_line), .cs_out, .link_plus_in(lp_in),
    .link_minus_in(lm_in), .link_plus, .link_minus, .link_oe, .awake);
  isb_spi_slave_model isb_spi_slave_model_i (.mclk, .cs_line, .sck_line, .cpol, .cpha,
    .pattern(2'h2), .miso_pull);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  // straps only change under reset
  task automatic restart(input logic r, input logic p, input logic a, input logic s,
                         input logic e);
    @(posedge mclk);
    srst <= 1'b1;
    role <= r;
    cpol <= p;
    cpha <= a;
    slow <= s;
    en   <= e;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (12) @(posedge mclk);
    #1;
  endtask : restart
  task automatic get_pulse();
    int n;
    n = 0;
    h1 = 32'h0;
    h2 = 32'h0;
    while (link_oe !== 1'b1 && n < 300) begin
      @(posedge mclk);
      #1;
      n++;
    end
    neg = link_minus;
    while (link_oe === 1'b1 && link_minus === neg && link_plus === !neg) begin
      h1++;
      @(posedge mclk);
      #1;
    end
    while (link_oe === 1'b1 && link_minus === !neg && link_plus === neg) begin
      h2++;
      @(posedge mclk);
      #1;
    end
  endtask : get_pulse
  task automatic expect_pulse(input string what, input logic n, input int half);
    get_pulse();
    chk(what, neg, n);
    chk(what, h1, half);
    chk(what, h2, half);
  endtask : expect_pulse
  // far bridge: first half then inverted half, then idle
  task automatic send_pulse(input logic n, input int half);
    @(posedge mclk);
    lm_in <= n;
    lp_in <= !n;
    repeat (half) @(posedge mclk);
    lm_in <= !n;
    lp_in <= n;
    repeat (half) @(posedge mclk);
    lm_in <= 1'b0;
    lp_in <= 1'b0;
  endtask : send_pulse
  task automatic edge_after(input int gap, input logic cs, input logic sck, input logic d);
    repeat (gap) @(posedge mclk);
    m_mosi <= d;
    @(posedge mclk);
    m_cs  <= cs;
    m_sck <= sck;
  endtask : edge_after
  initial begin
    restart(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    chk("awake", awake, 1'b1);
    chk("master oe", {mosi_out.oe, miso_out.oe, sck_out.oe, cs_out.oe}, 4'h0);
    edge_after(1, 1'b0, 1'b0, 1'b0);
    expect_pulse("cs fall", 1'b1, isb_pkg::LONG_HALF_CYC);
    edge_after(60, 1'b0, 1'b1, 1'b1);
    expect_pulse("data one", 1'b0, isb_pkg::SHORT_HALF_CYC);
    send_pulse(1'b1, isb_pkg::SHORT_HALF_CYC);
    repeat (10) @(posedge mclk);
    #1;
    chk("miso pulled", miso_out.oe, 1'b1);
    edge_after(20, 1'b0, 1'b0, 1'b0);
    edge_after(20, 1'b0, 1'b1, 1'b0);
    expect_pulse("data zero", 1'b1, isb_pkg::SHORT_HALF_CYC);
    repeat (20) @(posedge mclk);
    #1;
    chk("miso released", miso_out.oe, 1'b0);
    edge_after(20, 1'b0, 1'b0, 1'b0);
    edge_after(60, 1'b1, 1'b0, 1'b0);
    expect_pulse("cs rise", 1'b0, isb_pkg::LONG_HALF_CYC);
    restart(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    chk("slave oe", {sck_out.oe, cs_out.oe, miso_out.oe}, 3'h6);
    chk("sck idle", sck_out.o, 1'b1);
    send_pulse(1'b1, isb_pkg::LONG_HALF_CYC);
    expect_pulse("cs fall return", 1'b1, isb_pkg::SHORT_HALF_CYC);
    chk("cs low", cs_out.o, 1'b0);
    send_pulse(1'b0, isb_pkg::SHORT_HALF_CYC);
    expect_pulse("zero bit return", 1'b1, isb_pkg::SHORT_HALF_CYC);
    chk("mosi released", mosi_out.oe, 1'b0);
    send_pulse(1'b1, isb_pkg::SHORT_HALF_CYC);
    get_pulse();
    chk("one bit no return", h1, 32'h0);
    chk("mosi pulled", mosi_out.oe, 1'b1);
    send_pulse(1'b0, isb_pkg::LONG_HALF_CYC);
    repeat (20) @(posedge mclk);
    #1;
    chk("cs high", {cs_out.o, sck_out.o}, 2'h3);
    restart(1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    chk("idle after reset", awake, 1'b0);
    send_pulse(1'b1, isb_pkg::LONG_HALF_CYC);
    expect_pulse("wake return", 1'b1, isb_pkg::SHORT_HALF_CYC);
    chk("woken", {awake, sck_out.o, cs_out.o}, 3'h4);
    send_pulse(1'b1, isb_pkg::SHORT_HALF_CYC);
    expect_pulse("slow phase return", 1'b1, isb_pkg::SHORT_HALF_CYC);
    chk("no early idle", awake, 1'b1);
    summarize();
  end
  initial begin
    #1000000;
    err_total++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
